/* verilog/fh_ext_cfg.svh */
`ifndef FH_EXT_CFG_SVH
`define FH_EXT_CFG_SVH
`define TYPE_BEAM 7'h0a
`define TYPE_MODCOMP 7'h05
`define TYPE_CONSOL 7'h13
`define MODCOMP_END 10'h006
`define BEAM_FIRST 10'h003
`define CONSOL_FIRST 10'h005
`define IDX_BODY0 10'h002
`define IDX_B3 10'h003
`define IDX_B4 10'h004
`define IDX_B5 10'h005
`define MAX_PORTS 6'h10
`define DESC_LAST 3'h7
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_HIMASK 4'h2
`define REG_BADCNT 4'h3
`endif

/* verilog/fh_ext_pkg.sv */
package fh_ext_pkg;
  typedef enum logic [1:0] {S_IDLE, S_TYPE, S_LEN, S_BODY} parse_state_t;
  typedef logic [14:0] beam_index_t;
endpackage : fh_ext_pkg

/* verilog/fronthaul_section_ext_parser.sv */
`timescale 1ns/10ps
`include "fh_ext_cfg.svh"
// How it works
// - single set: mask nibble, shift flag, offset top
// - single-set extension length is two words
// - consolidated section carries up to 16 ports
// - type-19 resource handled as one section
// - header mask plus extension symbol bitmap combined
// - highest-priority masks clear overlapping lower masks
// - plain section descriptions stepped in 8 bytes
// - extra port: reserved bit, 15-bit beam index
// - one modulation extension per stream follows beam
module fronthaul_section_ext_parser (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic byteLast,
  input wire logic chainStart,
  input wire logic descValid,
  input wire logic slotStart,
  input wire logic secValid,
  input wire logic secHighPrio,
  input wire logic [11:0] secReMask,
  input wire logic fragRepeat,
  input wire logic [3:0] consolPortSel,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic portValid,
  output logic [4:0] portNum,
  output logic [14:0] portBeam,
  output logic [1:0] beamGroupMode,
  output logic modValid,
  output logic [2:0] modStream,
  output logic [11:0] modReMask,
  output logic modCsf,
  output logic [14:0] modOffset,
  output logic consolValid,
  output logic [11:0] consolReMask,
  output logic [13:0] consolSymbols,
  output logic [4:0] consolPorts,
  output logic [14:0] consolPortBeam,
  output logic effValid,
  output logic [11:0] effReMask,
  output logic descDone,
  output logic extDone,
  output logic extBad
);
  fh_ext_pkg::parse_state_t state_q;
  logic enable_q, prioEn_q, badFlag_q, ef_q;
  logic [7:0] badCnt_q, len_q, mcOffMid_q, expWords;
  logic [6:0] type_q, hiBits_q;
  logic [9:0] idx_q, fieldEnd, lenBytes;
  logic [5:0] count_q;
  logic [11:0] hiMask_q, mcMask_q;
  logic [2:0] descCnt_q, mcOffHi_q;
  logic [13:0] symbols_q;
  logic [4:0] storedPorts_q;
  fh_ext_pkg::beam_index_t beamMem [16];
  logic hdrByte, bodyByte, lastByte, isBeam, isMod, isCon, padBad, portLow, badNow;
  assign hdrByte = byteValid && enable_q &&
    (state_q == fh_ext_pkg::S_TYPE || (state_q == fh_ext_pkg::S_IDLE && chainStart));
  assign bodyByte = byteValid && state_q == fh_ext_pkg::S_BODY;
  assign lenBytes = {len_q, 2'b00};
  assign lastByte = bodyByte && idx_q == lenBytes - 10'h001;
  assign isBeam = type_q == `TYPE_BEAM;
  assign isMod = type_q == `TYPE_MODCOMP;
  assign isCon = type_q == `TYPE_CONSOL;
  // end of meaningful fields; everything past it is padding
  assign fieldEnd = isMod ? `MODCOMP_END : isBeam ? `BEAM_FIRST + {3'h0, count_q, 1'b0} :
    isCon ? `CONSOL_FIRST + {3'h0, count_q, 1'b0} : lenBytes;
  assign expWords = 8'((fieldEnd + 10'h003) >> 2);
  // low nibble of the last single-set byte is padding too
  assign padBad = bodyByte && ((idx_q >= fieldEnd && byteData != 8'h00) ||
    (isMod && idx_q == `IDX_B5 && byteData[3:0] != 4'h0));
  assign portLow = bodyByte && (isBeam || isCon) && idx_q < fieldEnd &&
    idx_q >= (isBeam ? `BEAM_FIRST : `CONSOL_FIRST) && !idx_q[0];
  assign badNow = padBad ||
    (lastByte && len_q != expWords) ||
    (bodyByte && isCon && idx_q == `IDX_B4 && byteData[5:0] > `MAX_PORTS) ||
    (state_q == fh_ext_pkg::S_LEN && byteValid && byteData == 8'h00) ||
    (byteValid && byteLast && state_q != fh_ext_pkg::S_IDLE && !hdrByte &&
     !(lastByte && !ef_q)) ||
    (hdrByte && byteLast);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= fh_ext_pkg::S_IDLE;
      ef_q <= 1'b0;
      type_q <= 7'h00;
      len_q <= 8'h00;
      idx_q <= 10'h000;
    end else if (byteValid && (byteLast || (badNow && !lastByte))) begin
      state_q <= fh_ext_pkg::S_IDLE;
    end else if (hdrByte) begin
      ef_q <= byteData[7];
      type_q <= byteData[6:0];
      state_q <= fh_ext_pkg::S_LEN;
    end else if (byteValid && state_q == fh_ext_pkg::S_LEN) begin
      len_q <= byteData;
      idx_q <= `IDX_BODY0;
      state_q <= fh_ext_pkg::S_BODY;
    end else if (bodyByte) begin
      idx_q <= idx_q + 10'h001;
      if (lastByte) begin
        state_q <= ef_q ? fh_ext_pkg::S_TYPE : fh_ext_pkg::S_IDLE;
      end
    end
  end
  // port counts and beam index assembly
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 6'h00;
      hiBits_q <= 7'h00;
      portNum <= 5'h00;
      portValid <= 1'b0;
      portBeam <= 15'h0000;
      beamGroupMode <= 2'h0;
    end else begin
      portValid <= portLow;
      if (hdrByte) begin
        count_q <= 6'h00;
        portNum <= 5'h00;
      end
      if (bodyByte && isBeam && idx_q == `IDX_BODY0) begin
        beamGroupMode <= byteData[7:6];
        count_q <= byteData[5:0];
      end
      if (bodyByte && isCon && idx_q == `IDX_B4) begin
        count_q <= byteData[5:0];
      end
      if (bodyByte && idx_q[0]) begin
        hiBits_q <= byteData[6:0];
      end
      if (portLow) begin
        portBeam <= {hiBits_q, byteData};
      end
      if (portValid) begin
        portNum <= portNum + 5'h01;
      end
    end
  end
  // consolidated ports survive until a fresh set replaces them
  always_ff @(posedge mclk) begin
    if (portLow && isCon && portNum < 5'(`MAX_PORTS)) begin
      beamMem[portNum[3:0]] <= {hiBits_q, byteData};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      consolPortBeam <= 15'h0000;
    end else begin
      consolPortBeam <= 5'(consolPortSel) < storedPorts_q ? beamMem[consolPortSel] : 15'h0000;
    end
  end
  // single scaler-set modulation compression, one per stream
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mcMask_q <= 12'h000;
      mcOffHi_q <= 3'h0;
      mcOffMid_q <= 8'h00;
      modValid <= 1'b0;
      modStream <= 3'h0;
      modReMask <= 12'h000;
      modCsf <= 1'b0;
      modOffset <= 15'h0000;
    end else begin
      modValid <= bodyByte && isMod && idx_q == `IDX_B5;
      if (modValid) begin
        modStream <= modStream + 3'h1;
      end
      if (hdrByte && byteData[6:0] == `TYPE_BEAM) begin
        modStream <= 3'h0;
      end
      if (bodyByte && isMod) begin
        if (idx_q == `IDX_BODY0) begin
          mcMask_q[11:4] <= byteData;
        end
        if (idx_q == `IDX_B3) begin
          mcMask_q[3:0] <= byteData[7:4];
          modCsf <= byteData[3];
          mcOffHi_q <= byteData[2:0];
        end
        if (idx_q == `IDX_B4) begin
          mcOffMid_q <= byteData;
        end
        if (idx_q == `IDX_B5) begin
          modReMask <= mcMask_q;
          modOffset <= {mcOffHi_q, mcOffMid_q, byteData[7:4]};
        end
      end
    end
  end
  // whole resource in one section: header mask plus ext bitmap
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      symbols_q <= 14'h0000;
      storedPorts_q <= 5'h00;
      consolValid <= 1'b0;
      consolReMask <= 12'h000;
      consolSymbols <= 14'h0000;
      consolPorts <= 5'h00;
    end else begin
      consolValid <= lastByte && isCon && !badNow;
      if (bodyByte && isCon && idx_q == `IDX_BODY0) begin
        symbols_q[13:8] <= byteData[5:0];
      end
      if (bodyByte && isCon && idx_q == `IDX_B3) begin
        symbols_q[7:0] <= byteData;
      end
      if (lastByte && isCon && !badNow) begin
        consolReMask <= secReMask;
        consolSymbols <= symbols_q;
        if (count_q != 6'h00 || !fragRepeat) begin
          storedPorts_q <= count_q[4:0];
          consolPorts <= count_q[4:0];
        end else begin
          consolPorts <= storedPorts_q;
        end
      end
    end
  end
  // accumulate high-priority masks, clear them from the rest
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hiMask_q <= 12'h000;
      effValid <= 1'b0;
      effReMask <= 12'h000;
    end else begin
      effValid <= secValid;
      if (secValid) begin
        effReMask <= (secHighPrio || !prioEn_q) ? secReMask : secReMask & ~hiMask_q;
      end
      if (slotStart) begin
        hiMask_q <= 12'h000;
      end else if (secValid && secHighPrio) begin
        hiMask_q <= hiMask_q | secReMask;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      descCnt_q <= 3'h0;
      descDone <= 1'b0;
    end else begin
      descDone <= descValid && descCnt_q == `DESC_LAST;
      if (descValid) begin
        descCnt_q <= descCnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      extDone <= 1'b0;
      extBad <= 1'b0;
    end else begin
      extDone <= lastByte;
      extBad <= byteValid && badNow;
    end
  end
  // register port; malformed flag is write-one-to-clear, set wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= 1'b1;
      prioEn_q <= 1'b1;
      badFlag_q <= 1'b0;
      badCnt_q <= 8'h00;
    end else begin
      if (regWr && regAddr == `REG_CTRL) begin
        enable_q <= regWdata[0];
        prioEn_q <= regWdata[1];
      end
      if (extBad) begin
        badFlag_q <= 1'b1;
        badCnt_q <= badCnt_q + (badCnt_q != 8'hff ? 8'h01 : 8'h00);
      end else if (regWr && regAddr == `REG_STATUS && regWdata[0]) begin
        badFlag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        `REG_CTRL: regRdata <= {30'h0, prioEn_q, enable_q};
        `REG_STATUS: regRdata <= {30'h0, state_q != fh_ext_pkg::S_IDLE, badFlag_q};
        `REG_HIMASK: regRdata <= {20'h0, hiMask_q};
        `REG_BADCNT: regRdata <= {24'h0, badCnt_q};
        default: regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_modHdr;
    hdrByte && byteData[6:0] == `TYPE_MODCOMP;
  endsequence

  chk_mod_len_two: assert property (lastByte && isMod && len_q != 8'h02 |=> extBad)
    else $error("single-set length not two words unflagged");
  chk_mod_fields: assert property (bodyByte && isMod && idx_q == `IDX_B5 && !byteLast
    |=> modValid && modReMask[3:0] == $past(mcMask_q[3:0]))
    else $error("mask low nibble misplaced");
  chk_mod_start: assert property (s_modHdr
    ##1 (byteValid && !byteLast && byteData != 8'h00)[*1] |-> ##[0:2] idx_q == `IDX_BODY0)
    else $error("length byte not consumed");
  chk_stream_step: assert property (modValid && modStream != 3'h7 && !$past(hdrByte)
    |=> modStream == $past(modStream) + 3'h1)
    else $error("stream index did not advance");
  chk_consol_max: assert property (consolValid |-> consolPorts <= 5'(`MAX_PORTS))
    else $error("too many consolidated ports");
  chk_consol_mask: assert property (lastByte && isCon && !badNow
    |=> consolValid && consolReMask == $past(secReMask))
    else $error("consolidated mask not header mask");
  chk_repeat_keep: assert property (lastByte && isCon && !badNow && count_q == 6'h00
    && fragRepeat |=> consolPorts == $past(storedPorts_q))
    else $error("stored ports not reused");
  chk_prio_clear: assert property (secValid && !secHighPrio && prioEn_q
    |=> (effReMask & $past(hiMask_q)) == 12'h000)
    else $error("overlap not cleared");
  chk_desc_eight: assert property (descDone |-> $past(descValid) && descCnt_q == 3'h0)
    else $error("description step not eight bytes");
  chk_beam_idx: assert property (portLow |=> portValid && portBeam[7:0] == $past(byteData))
    else $error("beam index low octet lost");
  chk_pad_zero: assert property (padBad |=> extBad)
    else $error("nonzero padding unflagged");
endmodule : fronthaul_section_ext_parser

/* verif/du_sender.sv */
`timescale 1ns/10ps
module du_sender (
  input wire logic mclk,
  output logic byteValid,
  output logic [7:0] byteData,
  output logic byteLast,
  output logic chainStart,
  output logic descValid
);
  logic [7:0] q[$];
  initial begin
    byteValid = 1'b0;
    byteData = 8'h00;
    byteLast = 1'b0;
    chainStart = 1'b0;
    descValid = 1'b0;
  end
  task push(input logic [7:0] b);
    q.push_back(b);
  endtask : push
  task mod5(input logic ef, input logic [11:0] m, input logic c, input logic [14:0] o);
    push({ef, 7'h05});
    push(8'h02);
    push(m[11:4]);
    push({m[3:0], c, o[14:12]});
    push(o[11:4]);
    push({o[3:0], 4'h0});
    push(8'h00);
    push(8'h00);
  endtask : mod5
  task port(input logic [14:0] bm);
    push({1'b0, bm[14:8]});
    push(bm[7:0]);
  endtask : port
  task flush;
    int n;
    n = q.size();
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      byteValid <= 1'b1;
      byteData <= q[i];
      chainStart <= (i == 0);
      byteLast <= (i == n - 1);
    end
    @(posedge mclk);
    byteValid <= 1'b0;
    chainStart <= 1'b0;
    byteLast <= 1'b0;
    // released line shows the inverse, not a stale byte
    byteData <= ~byteData;
    q.delete();
  endtask : flush
  task desc(input int n);
    repeat (n) @(posedge mclk) descValid <= 1'b1;
    @(posedge mclk);
    descValid <= 1'b0;
  endtask : desc
endmodule : du_sender

/* verif/fronthaul_section_ext_parser_test.sv */
`timescale 1ns/10ps
module fronthaul_section_ext_parser_test;
  logic mclk = 1'b0, rst_b = 1'b0;
  logic byteValid, byteLast, chainStart, descValid;
  logic [7:0] byteData;
  logic slotStart, secValid, secHighPrio, fragRepeat;
  logic [11:0] secReMask;
  logic [3:0] consolPortSel, regAddr;
  logic [31:0] regWdata, regRdata, d;
  logic regWr, regRd;
  logic portValid, modValid, modCsf, consolValid, effValid, descDone, extDone, extBad;
  logic [4:0] portNum, consolPorts;
  logic [14:0] portBeam, modOffset, consolPortBeam;
  logic [1:0] beamGroupMode;
  logic [2:0] modStream;
  logic [11:0] modReMask, consolReMask, effReMask;
  logic [13:0] consolSymbols;
  int error_cnt = 0, comparisons = 0, nMod = 0, nPort = 0, nBad = 0, nDesc = 0;
  int nDone = 0, nCon = 0;
  logic [11:0] em[4] = '{12'habc, 12'h123, 12'hfff, 12'h001};
  logic ec[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [14:0] eo[4] = '{15'h7fff, 15'h1000, 15'h0001, 15'h4a5b};
  logic [14:0] eb[3] = '{15'h1234, 15'h0777, 15'h7f00};
  always #12.5 mclk = ~mclk;
  du_sender du (.mclk(mclk), .byteValid(byteValid), .byteData(byteData),
    .byteLast(byteLast), .chainStart(chainStart), .descValid(descValid));
  fronthaul_section_ext_parser uut (.mclk(mclk), .rst_b(rst_b), .byteValid(byteValid),
    .byteData(byteData), .byteLast(byteLast), .chainStart(chainStart),
    .descValid(descValid), .slotStart(slotStart), .secValid(secValid),
    .secHighPrio(secHighPrio), .secReMask(secReMask), .fragRepeat(fragRepeat),
    .consolPortSel(consolPortSel), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .portValid(portValid),
    .portNum(portNum), .portBeam(portBeam), .beamGroupMode(beamGroupMode),
    .modValid(modValid), .modStream(modStream), .modReMask(modReMask), .modCsf(modCsf),
    .modOffset(modOffset), .consolValid(consolValid), .consolReMask(consolReMask),
    .consolSymbols(consolSymbols), .consolPorts(consolPorts),
    .consolPortBeam(consolPortBeam), .effValid(effValid), .effReMask(effReMask),
    .descDone(descDone), .extDone(extDone), .extBad(extBad));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task summarize;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask : rd
  task sec(input logic hp, input logic [11:0] m, input logic [11:0] exp);
    @(posedge mclk);
    secValid <= 1'b1;
    secHighPrio <= hp;
    secReMask <= m;
    @(posedge mclk);
    secValid <= 1'b0;
    #1 check(effValid, 1);
    check(effReMask, exp);
  endtask : sec
  always @(posedge mclk) begin
    if (modValid === 1'b1 && nMod < 4) begin
      check(modStream, nMod);
      check(modReMask, em[nMod]);
      check(modCsf, ec[nMod]);
      check(modOffset, eo[nMod]);
      nMod++;
    end
    if (portValid === 1'b1 && nPort < 3) begin
      check(portBeam, eb[nPort]);
      check(portNum, nPort);
      nPort++;
    end
    if (extBad === 1'b1) nBad++;
    if (descDone === 1'b1) nDesc++;
    if (extDone === 1'b1) nDone++;
    if (consolValid === 1'b1) nCon++;
  end
  initial begin
    #(25 * 5000);
    error_cnt++;
    summarize();
  end
  initial begin
    slotStart <= 1'b0;
    secValid <= 1'b0;
    secHighPrio <= 1'b0;
    fragRepeat <= 1'b0;
    secReMask <= 12'h000;
    consolPortSel <= 4'h0;
    regAddr <= 4'h0;
    regWdata <= 32'h0;
    regWr <= 1'b0;
    regRd <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd(4'h0, d);
    check(d, 32'h3);
    // beam extension with three extra ports, then one modulation extension per stream
    du.push(8'h8a);
    du.push(8'h03);
    du.push({2'h2, 6'h03});
    for (int i = 0; i < 3; i++) du.port(eb[i]);
    repeat (3) du.push(8'h00);
    for (int i = 0; i < 4; i++) du.mod5(i < 3, em[i], ec[i], eo[i]);
    du.flush();
    repeat (3) @(posedge mclk);
    check(nMod, 4);
    check(nPort, 3);
    check(beamGroupMode, 2'h2);
    check(nBad, 0);
    check(nDone, 5);
    // length one word too long, then a message cut after its length byte
    du.push(8'h05);
    du.push(8'h03);
    repeat (10) du.push(8'h00);
    du.flush();
    repeat (3) @(posedge mclk);
    check(nBad, 1);
    du.push(8'h05);
    du.push(8'h03);
    du.flush();
    repeat (3) @(posedge mclk);
    check(nBad, 2);
    rd(4'h1, d);
    check(d, 32'h1);
    wr(4'h1, 32'h1);
    rd(4'h1, d);
    check(d, 32'h0);
    rd(4'h3, d);
    check(d, 32'h2);
    rd(4'hf, d);
    check(d, 32'h0);
    // consolidated resource, then a repeat without port info
    secReMask <= 12'h0f0;
    du.push(8'h13);
    du.push(8'h03);
    du.push(8'h2a);
    du.push(8'h5c);
    du.push(8'h02);
    du.port(eb[0]);
    du.port(eb[1]);
    repeat (3) du.push(8'h00);
    du.flush();
    consolPortSel <= 4'h1;
    repeat (3) @(posedge mclk);
    check(consolReMask, 12'h0f0);
    check(consolSymbols, 14'h2a5c);
    check(consolPorts, 5'h02);
    check(consolPortBeam, eb[1]);
    fragRepeat <= 1'b1;
    for (int i = 0; i < 8; i++) du.push(i == 0 ? 8'h13 : (i == 1 ? 8'h02 : 8'h00));
    du.flush();
    repeat (3) @(posedge mclk);
    check(consolPorts, 5'h02);
    check(consolPortBeam, eb[1]);
    check(nBad, 2);
    check(nCon, 2);
    fragRepeat <= 1'b0;
    // priority masking within a slot
    @(posedge mclk);
    slotStart <= 1'b1;
    @(posedge mclk);
    slotStart <= 1'b0;
    sec(1'b1, 12'h0f0, 12'h0f0);
    sec(1'b0, 12'hfff, 12'hf0f);
    rd(4'h2, d);
    check(d, 32'h0f0);
    wr(4'h0, 32'h1);
    sec(1'b0, 12'hfff, 12'hfff);
    du.desc(16);
    repeat (3) @(posedge mclk);
    check(nDesc, 2);
    summarize();
  end
endmodule : fronthaul_section_ext_parser_test
